/* File: rtl/fia_top.sv */
// Operation
// - 8K flash spans 0000h to 1FFFh.
// - top sixteen bytes hold configuration word.
// - 1F00h to 1FEFh writable without full-range.
// - 0000h to 1EFFh writable only with full-range.
// - 65h to 97h sets full-range, else clears.
// - code reads reach everything, no wait.
// - byte 1FFFh never writable.
// - 1FF0h to 1FFEh need full-range flag.
// - boot copies config bytes to F6h, F5h.
// - store uses active pointer and accumulator byte.
// - writes taken only with write enable set.
// - byte program stalls CPU about 0.5 ms.
// - byte writes need no page erase.
// - timeout frees CPU from failed write.
// - reset clears full-range flag.
// - 0000h to 007Fh reserved for vectors.
// - two physical 16-bit data pointers.
// - bit 0 of F8h selects active pointer.
// - 47h to C9h sets enable, E2h leaves it, else clears.
// - two-bit field picks timeout or disables.
// - timeout flag set by hardware, cleared with enable.
// - bit 0 of 97h reads full-range flag.
`timescale 1ns/10ps
`include "fia_map.svh"

module fia_top
#(
    parameter int PROG_CYCLES = `FIA_PROG_US * `FIA_CLK_MHZ,
    parameter int TO1_CYCLES = `FIA_TO1_US * `FIA_CLK_MHZ,
    parameter int TO2_CYCLES = `FIA_TO2_US * `FIA_CLK_MHZ,
    parameter int TO3_CYCLES = `FIA_TO3_US * `FIA_CLK_MHZ
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // code-space reads
    input wire logic [15:0] code_rd_addr,
    output logic [7:0] code_rd_data,
    // external-data store from the core
    input wire logic xdata_wr,
    input wire logic [7:0] xdata_acc,
    output logic [15:0] data_pointer,
    output logic cpu_wait,
    // programming supply good, asynchronous pin
    input wire logic supply_ok_pin,
    // configuration copies
    output logic [7:0] config_low_byte,
    output logic [7:0] bandgap_config_byte
);
    import fia_pkg::*;

    fia_state_t state_q;
    fia_state_t state_d;
    logic [7:0] dp_lo_q [0:1];
    logic [7:0] dp_hi_q [0:1];
    logic [7:0] aux_one_q;
    logic [7:0] aux_two_q;
    logic full_range_write_flag_q;
    logic flash_write_enable_flag_q;
    logic eeprom_write_enable_flag_q;
    logic write_timeout_flag_q;
    logic [7:0] cfg_lo_q;
    logic [7:0] cfg_bg_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic sup_meta_q;
    logic sup_sync_q;
    fia_count_t to_cnt_q;

    // apb decode, one aligned word per register, zero wait states
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite && pstrb[0];
    wire word_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    wire [7:0] idx = paddr[9:2];
    wire hit_ptr_lo = word_ok && (idx == `FIA_IDX_PTR_LO);
    wire hit_ptr_hi = word_ok && (idx == `FIA_IDX_PTR_HI);
    wire hit_cmd = word_ok && (idx == `FIA_IDX_CMD);
    wire hit_wren = word_ok && (idx == `FIA_IDX_WREN);
    wire hit_cfg_bg = word_ok && (idx == `FIA_IDX_CFG_BG);
    wire hit_cfg_lo = word_ok && (idx == `FIA_IDX_CFG_LO);
    wire hit_aux_two = word_ok && (idx == `FIA_IDX_AUX_TWO);
    wire hit_aux_one = word_ok && (idx == `FIA_IDX_AUX_ONE);
    wire hit_any = hit_ptr_lo || hit_ptr_hi || hit_cmd || hit_wren
        || hit_cfg_bg || hit_cfg_lo || hit_aux_two || hit_aux_one;
    wire [7:0] wbyte = pwdata[7:0];

    // active pointer chosen by the select bit
    wire psel_bit = aux_one_q[`FIA_AUX_ONE_PSEL];
    wire [7:0] act_lo = dp_lo_q[psel_bit];
    wire [7:0] act_hi = dp_hi_q[psel_bit];
    wire [15:0] act_ptr = {act_hi, act_lo};

    // status byte of the write enable register
    wire [7:0] wren_rd = {flash_write_enable_flag_q, write_timeout_flag_q,
        eeprom_write_enable_flag_q, 5'h00};

    // read mux, captured in the setup phase so prdata comes from flops
    wire [7:0] rd_byte =
        hit_ptr_lo ? act_lo :
        hit_ptr_hi ? act_hi :
        hit_cmd ? {7'h00, full_range_write_flag_q} :
        hit_wren ? wren_rd :
        hit_cfg_bg ? cfg_bg_q :
        hit_cfg_lo ? cfg_lo_q :
        hit_aux_two ? aux_two_q :
        hit_aux_one ? aux_one_q : 8'h00;

    // partition checks on the store target
    wire in_flash = act_ptr <= `FIA_ADDR_LAST;
    wire in_free = (act_ptr >= `FIA_FREE_FIRST)
        && (act_ptr <= `FIA_FREE_LAST);
    wire in_all = act_ptr <= `FIA_ALL_LAST;
    wire in_cfg = (act_ptr >= `FIA_CFG_FIRST)
        && (act_ptr <= `FIA_ADDR_IAP_MAX);
    wire is_cfg_hi = act_ptr == `FIA_CFG_HI_ADDR;
    // vectors sit inside the full-range area and share its guard
    wire in_vec = act_ptr <= `FIA_VEC_LAST;
    wire addr_ok = in_flash && !is_cfg_hi
        && (in_free || (full_range_write_flag_q
        && (in_all || in_vec || in_cfg)));

    // a store is taken only when idle, enabled and in range
    wire accept = (state_q == ST_IDLE) && xdata_wr
        && flash_write_enable_flag_q && addr_ok;

    // timeout limit chosen by the period field
    wire [1:0] to_sel = aux_two_q[`FIA_AUX_TWO_TO_HI:`FIA_AUX_TWO_TO_LO];
    wire fia_count_t to_limit =
        (to_sel == 2'b01) ? 21'(TO1_CYCLES) :
        (to_sel == 2'b10) ? 21'(TO2_CYCLES) : 21'(TO3_CYCLES);
    wire to_fire = (state_q == ST_PROG) && (to_sel != 2'b00)
        && (to_cnt_q == to_limit - 21'd1);

    // flash array hookup, boot owns the read port until done
    wire prog_done;
    wire [7:0] flash_rd;
    wire [12:0] flash_rd_addr =
        (state_q == ST_BOOT_BG) ? `FIA_CFG_BG_ADDR :
        (state_q == ST_BOOT_LO) ? `FIA_CFG_LO_ADDR :
        code_rd_addr[12:0];

    fia_flash_array u_flash
    (
        .pclk(pclk),
        .presetn(presetn),
        .rd_addr(flash_rd_addr),
        .rd_data(flash_rd),
        .prog_start(accept),
        .prog_abort(to_fire),
        .prog_addr(act_ptr[12:0]),
        .prog_data(xdata_acc),
        .supply_ok(sup_sync_q),
        .prog_cycles(21'(PROG_CYCLES)),
        .prog_done(prog_done)
    );

    // supply pin crosses in through two flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sup_meta_q <= 1'b0;
            sup_sync_q <= 1'b0;
        end
        else
        begin
            sup_meta_q <= supply_ok_pin;
            sup_sync_q <= sup_meta_q;
        end
    end

    // sequencer: boot copy, idle, then stall while a byte programs
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_BOOT_BG:
                state_d = ST_BOOT_LO;
            ST_BOOT_LO:
                state_d = ST_BOOT_END;
            ST_BOOT_END:
                state_d = ST_IDLE;
            ST_IDLE:
                if (accept)
                    state_d = ST_PROG;
            ST_PROG:
                if (prog_done || to_fire)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= ST_BOOT_BG;
        else
            state_q <= state_d;
    end

    // timeout counter runs only while a byte is in flight
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            to_cnt_q <= '0;
        else if (state_q == ST_PROG)
            to_cnt_q <= to_cnt_q + 21'd1;
        else
            to_cnt_q <= '0;
    end

    // two physical pointers, same offsets, select bit steers writes
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ptr
            wire mine = (psel_bit == 1'(g));
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    dp_lo_q[g] <= `FIA_DP_RST;
                    dp_hi_q[g] <= `FIA_DP_RST;
                end
                else if (wr_en && mine)
                begin
                    if (hit_ptr_lo)
                        dp_lo_q[g] <= wbyte;
                    if (hit_ptr_hi)
                        dp_hi_q[g] <= wbyte;
                end
            end
        end
    endgenerate

    // auxiliary controls; reserved bit 1 of auxiliary_control_one stays zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            aux_one_q <= `FIA_AUX_ONE_RST;
            aux_two_q <= `FIA_AUX_TWO_RST;
        end
        else if (wr_en)
        begin
            if (hit_aux_one)
                aux_one_q <= wbyte & ~(8'h01 << `FIA_AUX_ONE_RSVD);
            if (hit_aux_two)
                aux_two_q <= wbyte;
        end
    end

    // full-range flag, cleared at reset so only the free area is open
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            full_range_write_flag_q <= 1'b0;
        else if (wr_en && hit_cmd)
            full_range_write_flag_q <= (wbyte == `FIA_CMD_FULL);
    end

    // write enable pair, any stray value drops both
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flash_write_enable_flag_q <= 1'b0;
            eeprom_write_enable_flag_q <= 1'b0;
        end
        else if (wr_en && hit_wren)
        begin
            if (wbyte == `FIA_CMD_IAP_WE)
                flash_write_enable_flag_q <= 1'b1;
            else if (wbyte == `FIA_CMD_EEP_WE)
                eeprom_write_enable_flag_q <= 1'b1;
            else
            begin
                flash_write_enable_flag_q <= 1'b0;
                eeprom_write_enable_flag_q <= 1'b0;
            end
        end
    end

    // timeout flag: set wins over the clear in the same cycle
    wire we_any = flash_write_enable_flag_q || eeprom_write_enable_flag_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            write_timeout_flag_q <= 1'b0;
        else
            write_timeout_flag_q <= to_fire
                || (write_timeout_flag_q && we_any);
    end

    // config copies load once after reset, software may override later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_bg_q <= `FIA_CFG_RST;
            cfg_lo_q <= `FIA_CFG_RST;
        end
        else if (state_q == ST_BOOT_LO)
            cfg_bg_q <= flash_rd;
        else if (state_q == ST_BOOT_END)
            cfg_lo_q <= flash_rd;
        else if (wr_en)
        begin
            if (hit_cfg_bg)
                cfg_bg_q <= wbyte;
            if (hit_cfg_lo)
                cfg_lo_q <= wbyte;
        end
    end

    // apb answer, unmapped offsets flag an error and read zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata_q <= {24'h000000, rd_byte};
            pslverr_q <= !hit_any;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign pready = 1'b1;

    // core side; code reads bypass the write gates entirely
    assign code_rd_data = flash_rd;
    assign data_pointer = act_ptr;
    // interrupts stay pending in the core while this is high
    assign cpu_wait = (state_q != ST_IDLE);
    assign config_low_byte = cfg_lo_q;
    assign bandgap_config_byte = cfg_bg_q;

endmodule

/* File: rtl/fia_map.svh */
`ifndef FIA_MAP_SVH
`define FIA_MAP_SVH

// flash geometry and partition
`define FIA_FLASH_BYTES 8192
`define FIA_ADDR_LAST 16'h1fff
`define FIA_ADDR_IAP_MAX 16'h1ffe
`define FIA_ALL_LAST 16'h1eff
`define FIA_FREE_FIRST 16'h1f00
`define FIA_FREE_LAST 16'h1fef
`define FIA_CFG_FIRST 16'h1ff0
`define FIA_VEC_LAST 16'h007f
`define FIA_CFG_BG_ADDR 13'h1ffb
`define FIA_CFG_LO_ADDR 13'h1ffd
`define FIA_CFG_HI_ADDR 16'h1fff
`define FIA_ERASED 8'hff

// register indices, byte address is four times the index
`define FIA_IDX_PTR_LO 8'h82
`define FIA_IDX_PTR_HI 8'h83
`define FIA_IDX_CMD 8'h97
`define FIA_IDX_WREN 8'hc9
`define FIA_IDX_CFG_BG 8'hf5
`define FIA_IDX_CFG_LO 8'hf6
`define FIA_IDX_AUX_TWO 8'hf7
`define FIA_IDX_AUX_ONE 8'hf8

// command codes
`define FIA_CMD_FULL 8'h65
`define FIA_CMD_IAP_WE 8'h47
`define FIA_CMD_EEP_WE 8'he2

// field positions
`define FIA_AUX_ONE_PSEL 0
`define FIA_AUX_ONE_RSVD 1
`define FIA_AUX_TWO_TO_HI 2
`define FIA_AUX_TWO_TO_LO 1
`define FIA_WREN_IAP 7
`define FIA_WREN_TO 6
`define FIA_WREN_EEP 5

// reset values
`define FIA_AUX_ONE_RST 8'h0c
`define FIA_AUX_TWO_RST 8'h06
`define FIA_DP_RST 8'h00
`define FIA_CFG_RST 8'h00

// timing in microseconds at the core clock rate
`define FIA_CLK_MHZ 100
`define FIA_PROG_US 500
`define FIA_TO1_US 1600
`define FIA_TO2_US 3200
`define FIA_TO3_US 12800

`endif

/* File: rtl/fia_pkg.sv */
package fia_pkg;

    // sequencer states
    typedef enum logic [2:0]
    {
        ST_BOOT_BG,
        ST_BOOT_LO,
        ST_BOOT_END,
        ST_IDLE,
        ST_PROG
    } fia_state_t;

    typedef logic [20:0] fia_count_t;

endpackage

/* File: rtl/fia_flash_array.sv */
`timescale 1ns/10ps
`include "fia_map.svh"

module fia_flash_array
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // read port, one cycle latency
    input wire logic [12:0] rd_addr,
    output logic [7:0] rd_data,
    // byte program port
    input wire logic prog_start,
    input wire logic prog_abort,
    input wire logic [12:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic supply_ok,
    input wire fia_pkg::fia_count_t prog_cycles,
    output logic prog_done
);
    import fia_pkg::*;

    logic [7:0] mem [0:`FIA_FLASH_BYTES-1];
    logic busy_q;
    fia_count_t cnt_q;
    logic [12:0] addr_q;
    logic [7:0] data_q;
    logic done_q;
    wire last_cycle = busy_q && (cnt_q == prog_cycles - 21'd1);
    wire commit = last_cycle && supply_ok && !prog_abort;

    // blank array at power up, an erased flash reads all ones
    initial
    begin
        for (int i = 0; i < `FIA_FLASH_BYTES; i++)
            mem[i] = `FIA_ERASED;
    end

    // single byte commit, no page erase needed
    // plain always: the erased fill above also writes the array
    always @(posedge pclk)
    begin
        if (commit)
            mem[addr_q] <= data_q;
    end

    // program timer; a sagging supply holds it so the timeout can fire
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q <= 1'b0;
            cnt_q <= '0;
            addr_q <= 13'h0000;
            data_q <= 8'h00;
            done_q <= 1'b0;
            rd_data <= 8'h00;
        end
        else
        begin
            rd_data <= mem[rd_addr];
            done_q <= commit;
            if (prog_abort || commit)
                busy_q <= 1'b0;
            else if (prog_start)
            begin
                busy_q <= 1'b1;
                cnt_q <= '0;
                addr_q <= prog_addr;
                data_q <= prog_data;
            end
            else if (busy_q && supply_ok)
                cnt_q <= cnt_q + 21'd1;
        end
    end

    assign prog_done = done_q;

endmodule

/* File: verification/fia_top_properties.sv */
`timescale 1ns/10ps
module fia_top_checker
#(
    parameter int PROG_CYCLES = 20,
    parameter int TO1_CYCLES = 40,
    parameter int TO2_CYCLES = 80,
    parameter int TO3_CYCLES = 160
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // core side
    input wire logic xdata_wr,
    input wire logic [15:0] data_pointer,
    input wire logic cpu_wait
);
    logic full_q, we_q;
    logic [1:0] sel_q;
    int cnt_q, lim;
    // taken writes and stores; dp is the active pointer
    wire wr = psel && penable && pready && pwrite && pstrb[0];
    wire st = xdata_wr && !cpu_wait;
    wire [15:0] dp = data_pointer;
    assign lim = sel_q == 2'b01 ? TO1_CYCLES :
        sel_q == 2'b10 ? TO2_CYCLES : TO3_CYCLES;

    // shadow flags from the bus, so each store can be judged
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            full_q <= 1'b0;
            we_q <= 1'b0;
            sel_q <= 2'b11;
        end
        else if (wr)
        begin
            if (paddr == 12'h25c)
                full_q <= pwdata[7:0] == 8'h65;
            if (paddr == 12'h324 && pwdata[7:0] != 8'he2)
                we_q <= pwdata[7:0] == 8'h47;
            if (paddr == 12'h3dc)
                sel_q <= pwdata[2:1];
        end
    end

    // length of the running stall, too long for a repetition
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 0;
        else
            cnt_q <= cpu_wait ? cnt_q + 1 : 0;
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_top; st && dp > 16'h1fff |=> !cpu_wait; endproperty
    a_top: assert property (p_top)
        else $error("store above flash accepted");
    property p_free;
        st && we_q && dp >= 16'h1f00 && dp <= 16'h1fef |=> cpu_wait;
    endproperty
    a_free: assert property (p_free)
        else $error("free area store not taken");
    property p_prot; st && !full_q && dp <= 16'h1eff |=> !cpu_wait; endproperty
    a_prot: assert property (p_prot)
        else $error("protected code area written");
    property p_cfg;
        st && !full_q && dp >= 16'h1ff0 && dp <= 16'h1ffe |=> !cpu_wait;
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("config area written without full range");
    property p_we; st && !we_q |=> !cpu_wait; endproperty
    a_we: assert property (p_we)
        else $error("store taken with write enable clear");
    property p_prog;
        $fell(cpu_wait) |-> cnt_q <= 4 || cnt_q >= PROG_CYCLES;
    endproperty
    a_prog: assert property (p_prog)
        else $error("programming stall too short");
    property p_tmo; cpu_wait && sel_q != 2'b00 |-> cnt_q <= lim + 2; endproperty
    a_tmo: assert property (p_tmo)
        else $error("stall outlived the timeout");
    property p_full;
        psel && penable && !pwrite && paddr == 12'h25c |-> prdata[0] == full_q;
    endproperty
    a_full: assert property (p_full)
        else $error("full range readback wrong");

    c_prog: cover property ($fell(cpu_wait) && cnt_q >= PROG_CYCLES);
    c_drop: cover property (st && !we_q);
    c_tmo: cover property (cpu_wait && cnt_q == TO1_CYCLES);
endmodule

bind fia_top fia_top_checker #(.PROG_CYCLES(PROG_CYCLES),
    .TO1_CYCLES(TO1_CYCLES), .TO2_CYCLES(TO2_CYCLES),
    .TO3_CYCLES(TO3_CYCLES)) fia_top_checker_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .xdata_wr, .data_pointer, .cpu_wait);

/* File: verification/fia_cpu_model.sv */
`timescale 1ns/10ps
module fia_cpu_model
(
    // clock
    input wire logic pclk,
    // from the flash block
    input wire logic cpu_wait,
    input wire logic [7:0] code_rd_data,
    // to the flash block
    output logic xdata_wr,
    output logic [7:0] xdata_acc,
    output logic [15:0] code_rd_addr
);
    // idle core at start
    initial
    begin
        xdata_wr = 1'b0;
        xdata_acc = 8'h00;
        code_rd_addr = 16'h0000;
    end

    // store of the accumulator; a stalled core issues nothing
    task automatic store(input logic [7:0] b, output logic late);
        int k;
        for (k = 0; k < 400 && cpu_wait !== 1'b0; k++)
            @(posedge pclk);
        late = (k == 400);
        @(posedge pclk);
        xdata_acc <= b;
        xdata_wr <= 1'b1;
        @(posedge pclk);
        xdata_wr <= 1'b0;
        xdata_acc <= ~b; // stale byte, nobody may rely on a hold
    endtask

    // code fetch: address at one edge, byte after the next
    task automatic code_read(input logic [15:0] a, output logic [7:0] q);
        @(posedge pclk);
        code_rd_addr <= a;
        @(posedge pclk);
        #1;
        q = code_rd_data;
    endtask
endmodule

/* File: verification/tb_flash_iap_access_control.sv */
`timescale 1ns/10ps
module tb_flash_iap_access_control;
    localparam int PC = 20;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, supply_ok_pin = 1'b1, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, xdata_wr, cpu_wait;
    logic [15:0] code_rd_addr, data_pointer;
    logic [7:0] code_rd_data, xdata_acc, config_low_byte;
    logic [7:0] bandgap_config_byte, r, d;
    int errors = 0, num_checks = 0, i, n;
    // register indices and their values after boot
    logic [7:0] ri [8] = '{8'h82, 8'h83, 8'h97, 8'hc9, 8'hf7, 8'hf8,
        8'hf6, 8'hf5};
    logic [7:0] re [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h0c,
        8'hff, 8'hff};
    // store targets, full range set from the fifth on
    logic [15:0] pa [8] = '{16'h0040, 16'h1ff5, 16'h1fff, 16'h1200,
        16'h0040, 16'h1ffd, 16'h1fff, 16'h2000};
    logic [7:0] ok = 8'b0011_0000;
    int to [4] = '{0, 40, 80, 160};

    always #5 pclk = ~pclk;

    fia_top #(.PROG_CYCLES(PC), .TO1_CYCLES(40), .TO2_CYCLES(80),
        .TO3_CYCLES(160)) fia_top_inst
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'h1), .prdata, .pready, .pslverr, .code_rd_addr,
        .code_rd_data, .xdata_wr, .xdata_acc, .data_pointer, .cpu_wait,
        .supply_ok_pin, .config_low_byte, .bandgap_config_byte
    );
    fia_cpu_model fia_cpu_model_inst
    (
        .pclk, .cpu_wait, .code_rd_data, .xdata_wr, .xdata_acc,
        .code_rd_addr
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic hang();
        errors++;
        $display("BAD wait expected done seen stuck");
        complete_run();
    endtask

    task automatic chk(input string s, input logic [15:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask

    // one apb transfer by register index
    task automatic apb(input logic w, input logic [7:0] x, v,
        output logic [7:0] q);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, x, 2'b00};
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
            hang();
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic ptr(input logic [15:0] a);
        apb(1'b1, 8'h82, a[7:0], r);
        apb(1'b1, 8'h83, a[15:8], r);
    endtask

    // store, then count stall cycles into n
    task automatic st(input logic [7:0] b);
        logic late;
        fia_cpu_model_inst.store(b, late);
        if (late)
            hang();
        n = 0;
        #1;
        while (cpu_wait === 1'b1)
        begin
            @(posedge pclk);
            #1;
            n++;
            if (n > 2000)
                hang();
        end
    endtask

    // code read must never stall the core
    task automatic cr(input logic [15:0] a, input logic [7:0] e);
        fia_cpu_model_inst.code_read(a, d);
        chk("code", 16'(e), 16'(d));
        chk("nowait", 16'h0, 16'(cpu_wait));
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            apb(1'b0, ri[i], 8'h00, r);
            chk("reg", 16'(re[i]), 16'(r));
        end
        apb(1'b0, 8'h00, 8'h00, r);
        chk("unmapped", 16'h1, 16'(err));
        $display("test reset done");
        ptr(16'h1234);
        chk("dp", 16'h1234, data_pointer);
        apb(1'b1, 8'hf8, 8'h0d, r);
        chk("dp", 16'h0000, data_pointer);
        ptr(16'h1f00);
        apb(1'b1, 8'hf8, 8'h0c, r);
        apb(1'b0, 8'h82, 8'h00, r);
        chk("ptr_lo", 16'h0034, 16'(r));
        apb(1'b1, 8'hf8, 8'h0d, r);
        $display("test pointers done");
        apb(1'b1, 8'hc9, 8'he2, r);
        apb(1'b0, 8'hc9, 8'h00, r);
        chk("wren", 16'h1, 16'(r[7:5]));
        st(8'h5a);
        chk("stall", 16'h0, 16'(n));
        cr(16'h1f00, 8'hff);
        apb(1'b1, 8'hc9, 8'h47, r);
        apb(1'b0, 8'hc9, 8'h00, r);
        chk("wren", 16'h2, 16'(r[7:6]));
        st(8'h5a);
        chk("prog", 16'h1, 16'(n >= PC && n <= PC + 2));
        cr(16'h1f00, 8'h5a);
        st(8'ha5);
        cr(16'h1f00, 8'ha5);
        $display("test free area done");
        for (i = 0; i < 8; i++)
        begin
            if (i == 4)
            begin
                apb(1'b1, 8'h97, 8'h65, r);
                apb(1'b0, 8'h97, 8'h00, r);
                chk("full", 16'h1, 16'(r));
            end
            ptr(pa[i]);
            st(8'h60 + 8'(i));
            chk("taken", 16'(ok[i]), 16'(n > 0));
            cr(pa[i], ok[i] ? 8'h60 + 8'(i) : 8'hff);
        end
        $display("test protection done");
        ptr(16'h1f10);
        @(posedge pclk);
        supply_ok_pin <= 1'b0;
        for (i = 1; i < 4; i++)
        begin
            apb(1'b1, 8'hf7, 8'(i * 2), r);
            apb(1'b1, 8'hc9, 8'h47, r);
            st(8'h77);
            chk("tmo", 16'h1, 16'(n >= to[i] - 3 && n <= to[i] + 3));
            apb(1'b0, 8'hc9, 8'h00, r);
            chk("toflag", 16'h3, 16'(r[7:6]));
            apb(1'b1, 8'hc9, 8'h00, r);
            apb(1'b0, 8'hc9, 8'h00, r);
            chk("toflag", 16'h0, 16'(r[7:6]));
        end
        cr(16'h1f10, 8'hff);
        apb(1'b1, 8'hf7, 8'h00, r);
        apb(1'b1, 8'hc9, 8'h47, r);
        fork
            begin
                repeat (300) @(posedge pclk);
                supply_ok_pin <= 1'b1;
            end
        join_none
        st(8'h3c);
        chk("untimed", 16'h1, 16'(n > 290));
        cr(16'h1f10, 8'h3c);
        $display("test timeout done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // config copies are complete only as the boot stall ends
        for (i = 0; i < 20 && cpu_wait !== 1'b0; i++)
            @(posedge pclk);
        if (i == 20)
            hang();
        apb(1'b0, 8'hf6, 8'h00, r);
        chk("cfg", 16'h0065, 16'(r));
        chk("cfg", 16'h0065, 16'(config_low_byte));
        chk("bg", 16'h00ff, 16'(bandgap_config_byte));
        apb(1'b0, 8'h97, 8'h00, r);
        chk("full", 16'h0, 16'(r));
        apb(1'b1, 8'h97, 8'h65, r);
        apb(1'b1, 8'h97, 8'h66, r);
        apb(1'b0, 8'h97, 8'h00, r);
        chk("full", 16'h0, 16'(r));
        apb(1'b1, 8'hf6, 8'h12, r);
        chk("cfg", 16'h0012, 16'(config_low_byte));
        $display("test config done");
        complete_run();
    end
endmodule
